/* hdl/fcfs_pkg.sv */
/*
  constants, register map and carrier types of the fan supervisor.
  assumes a 200 mhz system clock and a byte-wide register space behind smbus.
*/
package fcfs_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] FCFS_REG_DUTY1 = 8'h30;
  localparam logic [7:0] FCFS_REG_DUTY2 = 8'h31;
  localparam logic [7:0] FCFS_REG_DUTY3 = 8'h32;
  localparam logic [7:0] FCFS_REG_ADAPT1 = 8'h36;
  localparam logic [7:0] FCFS_REG_TEST = 8'h6f;
  localparam logic [7:0] FCFS_REG_CFG = 8'h40;
  localparam logic [7:0] FCFS_REG_STAT1 = 8'h41;
  localparam logic [7:0] FCFS_REG_TACH1 = 8'h28;
  localparam logic [7:0] FCFS_REG_OTTIME = 8'h50;
  localparam logic [7:0] FCFS_REG_FAIL1 = 8'h54;
  localparam logic [7:0] FCFS_REG_BHVR1 = 8'h5c;
  localparam logic [7:0] FCFS_REG_MIN1 = 8'h64;
  localparam logic [7:0] FCFS_REG_START1 = 8'h67;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int FCFS_CORE_LOW_EN_BIT = 1;
  localparam int FCFS_ADAPT_EN_BIT = 0;
  localparam int FCFS_XOR_EN_BIT = 0;
  localparam int FCFS_ALERT_EN_BIT = 1;
  localparam int FCFS_STAT_CORE_BIT = 1;
  localparam int FCFS_STAT_FAN_LSB = 4;
  localparam int FCFS_DRIVE_BEHAVIOUR_FIELD_LSB = 5;
  localparam logic [2:0] FCFS_DRIVE_BEHAVIOUR_FIELD_MANUAL = 3'h7;
  localparam logic [7:0] FCFS_DUTY_RST = 8'h00;
  localparam logic [7:0] FCFS_DUTY_FULL = 8'hff;
  localparam logic [7:0] FCFS_DRIVE_BEHAVIOUR_FIELD_RST = 8'h00;
  localparam logic [7:0] FCFS_MIN_RST = 8'h40;
  localparam logic [7:0] FCFS_START_RST = 8'h5a;
  localparam logic [7:0] FCFS_FAIL_RST = 8'hff;
  localparam logic [7:0] FCFS_CFG_RST = 8'h00;
  localparam logic [6:0] FCFS_SMB_ADDR = 7'h2e;
  localparam int FCFS_AUTO_GAIN_SHIFT = 3;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint FCFS_CLK_HZ = 200000000;
  localparam longint FCFS_FAILSAFE_MS = 4600;
  localparam longint FCFS_FAILSAFE_CYC = FCFS_FAILSAFE_MS * FCFS_CLK_HZ / 1000;
  localparam longint FCFS_TICK_US = 10;
  localparam logic [15:0] FCFS_TICK_CYC = 16'(FCFS_TICK_US * FCFS_CLK_HZ / 1000000);
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0][7:0] duty;
  } fcfs_drive_t;
  typedef struct packed {
    logic [2:0][7:0] temp;
  } fcfs_temp_t;
  typedef struct packed {
    logic below_low_limit;
    logic detect_high;
  } fcfs_rail_t;
  typedef enum logic [2:0] {FS_POLL, FS_WAIT_ADDR, FS_COUNT, FS_FULL, FS_NORMAL} fcfs_fs_t;
  typedef enum logic [2:0] {SM_IDLE, SM_ADDR, SM_PTR, SM_WDATA, SM_RDATA} fcfs_smb_t;
endpackage : fcfs_pkg

/* hdl/fcfs_supervisor.sv */
/*
  fan supervisor: smbus register slave, fail-safe power-on timer, core rail
  low handling, automatic fan control, tach measurement, xor board test and
  pwm generation on its own link clock.
  assumes temperatures and rail comparisons arrive on the system clock.
*/
// Function
// - host reads back the duty actually driven on each fan output.
// - live duty registers reset to zero on all three channels.
// - core rail low with enable set raises status bit one.
// - core rail low drives alert only if alert generation enabled.
// - core rail low suspends overtemp monitoring; timer holds its value.
// - core rail low freezes start temperature adjustment.
// - core rail low blocks entry into shutdown.
// - rail back above limit re-enables everything and resumes normal work.
// - test enable bit zero routes listed pins through the xor chain.
// - rail low at power-up: defaults apply once addressed.
// - rail high at power-up: countdown; expiry forces full speed.
// - addressed after expiry: fans stop, defaults load, normal operation.
// - addressed before expiry: normal operation with defaults, no full speed.
// - configured device runs automatic fan control on its own.
// - three temperature channels control the three fan outputs.
// - speed of four fans is measured.
// - each temperature channel has its own start temperature setting.
// - each output has own minimum duty, fail threshold and ramp rate.
// - duty is eight bits, zero to full in steps of 1/256, the last step 2/256.
// - manual behaviour lets host writes set the duty directly.
`timescale 1ns/100ps
module fcfs_supervisor #(
  parameter longint FAILSAFE_CYC = fcfs_pkg::FCFS_FAILSAFE_CYC,
  parameter int NUM_TACH = 4
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_pwm,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  input wire fcfs_pkg::fcfs_temp_t i_temps,
  input wire fcfs_pkg::fcfs_rail_t i_rail,
  input wire logic [NUM_TACH-1:0] i_tach,
  input wire logic i_overtemp_pin_n,
  input wire logic i_shutdown_req,
  output logic o_alert,
  output logic o_overtemp_monitor_en,
  output logic o_start_temp_adjust_en,
  output logic o_shutdown,
  output logic o_xor_chain_out,
  output logic [2:0] o_fan_drive
);
  import fcfs_pkg::*;

  initial begin
    if (NUM_TACH != 4) $error("fan tach count must be four");
    if (FAILSAFE_CYC < 2 || FAILSAFE_CYC > 64'hffff_ffff) $error("bad fail-safe count");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NS = NUM_TACH + 3;
  logic [NS-1:0] pin_meta_q, pin_sync_q, pin_prev_q;
  always_ff @(posedge i_clk_sys) begin
    pin_meta_q <= {i_overtemp_pin_n, i_tach, i_sda, i_scl};
    pin_sync_q <= pin_meta_q;
    pin_prev_q <= pin_sync_q;
  end
  logic scl_s, sda_s, scl_rise, scl_fall, smb_start, smb_stop;
  logic [NUM_TACH-1:0] tach_s, tach_rise;
  logic overtemp_s;
  assign scl_s = pin_sync_q[0];
  assign sda_s = pin_sync_q[1];
  assign tach_s = pin_sync_q[NUM_TACH+1:2];
  assign overtemp_s = ~pin_sync_q[NS-1];
  assign scl_rise = scl_s & ~pin_prev_q[0];
  assign scl_fall = ~scl_s & pin_prev_q[0];
  assign smb_start = scl_s & pin_prev_q[0] & ~sda_s & pin_prev_q[1];
  assign smb_stop = scl_s & pin_prev_q[0] & sda_s & ~pin_prev_q[1];
  assign tach_rise = tach_s & ~pin_prev_q[NUM_TACH+1:2];

  // ----------------------------------------------------------------
  // smbus slave
  // ----------------------------------------------------------------
  fcfs_smb_t smb_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, ptr_q;
  logic rw_q, rd_nack_q, addr_ack_q, wr_q, rd_q;
  logic [7:0] wr_addr_q, wr_data_q, rd_addr_q, rd_data;
  always_ff @(posedge i_clk_sys) begin
    addr_ack_q <= 1'b0;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    if (i_rst) begin
      smb_q <= SM_IDLE;
      bit_cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      rd_nack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      rd_addr_q <= 8'h00;
    end else if (smb_start) begin
      smb_q <= SM_ADDR;
      bit_cnt_q <= 4'hf; // scl fall closing the start is no bit
      o_sda_oe <= 1'b0;
    end else if (smb_stop) begin
      smb_q <= SM_IDLE;
      o_sda_oe <= 1'b0;
    end else if (smb_q != SM_IDLE && scl_rise) begin
      if (bit_cnt_q < 4'h8) begin
        rx_q <= {rx_q[6:0], sda_s};
      end else begin
        rd_nack_q <= sda_s;
      end
    end else if (smb_q != SM_IDLE && scl_fall) begin
      if (bit_cnt_q == 4'h7) begin
        bit_cnt_q <= 4'h8;
        unique case (smb_q)
          SM_ADDR: begin
            if (rx_q[7:1] == FCFS_SMB_ADDR) begin
              o_sda_oe <= 1'b1;
              addr_ack_q <= 1'b1;
              rw_q <= rx_q[0];
            end else begin
              smb_q <= SM_IDLE;
            end
          end
          SM_PTR: begin
            ptr_q <= rx_q;
            o_sda_oe <= 1'b1;
          end
          SM_WDATA: begin
            wr_q <= 1'b1;
            wr_addr_q <= ptr_q;
            wr_data_q <= rx_q;
            ptr_q <= ptr_q + 8'h01;
            o_sda_oe <= 1'b1;
          end
          default: o_sda_oe <= 1'b0;
        endcase
      end else if (bit_cnt_q == 4'h8) begin
        bit_cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
        if ((smb_q == SM_ADDR && rw_q) || (smb_q == SM_RDATA && !rd_nack_q)) begin
          smb_q <= SM_RDATA;
          tx_q <= rd_data;
          o_sda_oe <= ~rd_data[7];
          rd_q <= 1'b1;
          rd_addr_q <= ptr_q;
          ptr_q <= ptr_q + 8'h01;
        end else if (smb_q == SM_ADDR) begin
          smb_q <= SM_PTR;
        end else if (smb_q == SM_PTR) begin
          smb_q <= SM_WDATA;
        end else if (smb_q == SM_RDATA) begin
          smb_q <= SM_IDLE;
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        if (smb_q == SM_RDATA) begin
          tx_q <= {tx_q[6:0], 1'b0};
          o_sda_oe <= ~tx_q[6];
        end
      end
    end
  end
  always_ff @(posedge i_clk_sys) o_sda_out <= 1'b0;

  // ----------------------------------------------------------------
  // fail-safe power-on sequencing
  // ----------------------------------------------------------------
  fcfs_fs_t fs_q;
  logic [31:0] fs_cnt_q;
  logic load_dflt_q;
  always_ff @(posedge i_clk_sys) begin
    load_dflt_q <= 1'b0;
    if (i_rst) begin
      fs_q <= FS_POLL;
      fs_cnt_q <= 32'h0;
    end else begin
      unique case (fs_q)
        FS_POLL: begin
          fs_q <= i_rail.detect_high ? FS_COUNT : FS_WAIT_ADDR;
          fs_cnt_q <= 32'(FAILSAFE_CYC - 1);
        end
        FS_WAIT_ADDR: if (addr_ack_q) begin
          fs_q <= FS_NORMAL;
          load_dflt_q <= 1'b1;
        end
        FS_COUNT: begin
          if (addr_ack_q) begin
            fs_q <= FS_NORMAL;
            fs_cnt_q <= 32'h0;
          end else if (fs_cnt_q == 32'h0) begin
            fs_q <= FS_FULL;
          end else begin
            fs_cnt_q <= fs_cnt_q - 32'h1;
          end
        end
        FS_FULL: if (addr_ack_q) begin
          fs_q <= FS_NORMAL;
          load_dflt_q <= 1'b1;
        end
        FS_NORMAL: fs_q <= FS_NORMAL;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] adapt_q, test_q, cfg_q;
  logic [2:0][7:0] drive_behaviour_field_q, min_q, start_q, fail_q, duty_q;
  logic [7:0] stat_q, ot_time_q;
  logic [NUM_TACH-1:0][15:0] tach_per_q;
  function automatic logic wr_hit(input logic [7:0] base, input int idx, input logic [7:0] a);
    wr_hit = (a == 8'(base + 8'(idx)));
  endfunction : wr_hit
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || load_dflt_q) begin
      adapt_q <= 8'h00;
      test_q <= 8'h00;
      cfg_q <= FCFS_CFG_RST;
      drive_behaviour_field_q <= {3{FCFS_DRIVE_BEHAVIOUR_FIELD_RST}};
      min_q <= {3{FCFS_MIN_RST}};
      start_q <= {3{FCFS_START_RST}};
      fail_q <= {3{FCFS_FAIL_RST}};
    end else if (wr_q) begin
      if (wr_addr_q == FCFS_REG_ADAPT1) adapt_q <= wr_data_q;
      if (wr_addr_q == FCFS_REG_TEST) test_q <= wr_data_q;
      if (wr_addr_q == FCFS_REG_CFG) cfg_q <= wr_data_q;
      for (int c = 0; c < 3; c++) begin
        if (wr_hit(FCFS_REG_BHVR1, c, wr_addr_q)) drive_behaviour_field_q[c] <= wr_data_q;
        if (wr_hit(FCFS_REG_MIN1, c, wr_addr_q)) min_q[c] <= wr_data_q;
        if (wr_hit(FCFS_REG_START1, c, wr_addr_q)) start_q[c] <= wr_data_q;
        if (wr_hit(FCFS_REG_FAIL1, c, wr_addr_q)) fail_q[c] <= wr_data_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // core rail low suspension
  // ----------------------------------------------------------------
  logic rail_susp;
  assign rail_susp = adapt_q[FCFS_CORE_LOW_EN_BIT] & i_rail.below_low_limit;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_overtemp_monitor_en <= 1'b1;
      o_start_temp_adjust_en <= 1'b0;
      o_shutdown <= 1'b0;
    end else begin
      o_overtemp_monitor_en <= ~rail_susp;
      o_start_temp_adjust_en <= adapt_q[FCFS_ADAPT_EN_BIT] & ~rail_susp;
      o_shutdown <= i_shutdown_req & ~rail_susp;
    end
  end

  // ----------------------------------------------------------------
  // tick, tach periods and overtemp timer
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 16'h0);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tick) tick_cnt_q <= FCFS_TICK_CYC - 16'h1;
    else tick_cnt_q <= tick_cnt_q - 16'h1;
  end
  logic [NUM_TACH-1:0][15:0] tach_run_q;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tach_run_q <= '0;
      tach_per_q <= '1;
    end else begin
      for (int f = 0; f < NUM_TACH; f++) begin
        if (tach_rise[f]) begin
          tach_per_q[f] <= tach_run_q[f];
          tach_run_q[f] <= 16'h0;
        end else if (tick && tach_run_q[f] != 16'hffff) begin
          tach_run_q[f] <= tach_run_q[f] + 16'h1;
        end else if (tach_run_q[f] == 16'hffff) begin
          tach_per_q[f] <= 16'hffff;
        end
      end
    end
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) ot_time_q <= 8'h00;
    else if (tick && overtemp_s && !rail_susp && ot_time_q != 8'hff) begin
      ot_time_q <= ot_time_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // status, alert and read-back
  // ----------------------------------------------------------------
  logic [7:0] stat_set;
  logic stat_rd;
  always_comb begin
    stat_set = 8'h00;
    stat_set[FCFS_STAT_CORE_BIT] = rail_susp;
    for (int f = 0; f < NUM_TACH; f++) begin
      stat_set[FCFS_STAT_FAN_LSB + f] = tach_per_q[f][15:8] > fail_q[(f > 2) ? 2 : f];
    end
  end
  assign stat_rd = rd_q && rd_addr_q == FCFS_REG_STAT1;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stat_q <= 8'h00;
      o_alert <= 1'b0;
    end else begin
      stat_q <= (stat_rd ? 8'h00 : stat_q) | stat_set;
      o_alert <= cfg_q[FCFS_ALERT_EN_BIT] & (stat_q != 8'h00);
    end
  end
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q == FCFS_REG_ADAPT1) rd_data = adapt_q;
    if (ptr_q == FCFS_REG_TEST) rd_data = test_q;
    if (ptr_q == FCFS_REG_CFG) rd_data = cfg_q;
    if (ptr_q == FCFS_REG_STAT1) rd_data = stat_q;
    if (ptr_q == FCFS_REG_OTTIME) rd_data = ot_time_q;
    for (int c = 0; c < 3; c++) begin
      if (wr_hit(FCFS_REG_DUTY1, c, ptr_q)) rd_data = duty_q[c];
      if (wr_hit(FCFS_REG_BHVR1, c, ptr_q)) rd_data = drive_behaviour_field_q[c];
      if (wr_hit(FCFS_REG_MIN1, c, ptr_q)) rd_data = min_q[c];
      if (wr_hit(FCFS_REG_START1, c, ptr_q)) rd_data = start_q[c];
      if (wr_hit(FCFS_REG_FAIL1, c, ptr_q)) rd_data = fail_q[c];
    end
    for (int f = 0; f < NUM_TACH; f++) begin
      if (wr_hit(FCFS_REG_TACH1, f, ptr_q)) rd_data = tach_per_q[f][15:8];
    end
  end

  // ----------------------------------------------------------------
  // automatic control and live duty
  // ----------------------------------------------------------------
  function automatic logic [7:0] auto_target(input logic [7:0] t, input logic [7:0] s,
                                             input logic [7:0] m);
    logic [15:0] up;
    up = 16'(t - s) << FCFS_AUTO_GAIN_SHIFT;
    up = up + 16'(m);
    if (t < s) auto_target = 8'h00;
    else auto_target = (up > 16'h00ff) ? FCFS_DUTY_FULL : up[7:0];
  endfunction : auto_target
  logic [2:0][7:0] tgt;
  always_comb begin
    for (int c = 0; c < 3; c++) tgt[c] = auto_target(i_temps.temp[c], start_q[c], min_q[c]);
  end
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || load_dflt_q) begin
      duty_q <= {3{FCFS_DUTY_RST}};
    end else if (fs_q == FS_FULL) begin
      duty_q <= {3{FCFS_DUTY_FULL}};
    end else if (fs_q == FS_NORMAL) begin
      for (int c = 0; c < 3; c++) begin
        if (drive_behaviour_field_q[c][7:FCFS_DRIVE_BEHAVIOUR_FIELD_LSB] == FCFS_DRIVE_BEHAVIOUR_FIELD_MANUAL) begin
          if (wr_q && wr_hit(FCFS_REG_DUTY1, c, wr_addr_q)) duty_q[c] <= wr_data_q;
        end else if (drive_behaviour_field_q[c][2:0] == 3'h0) begin
          duty_q[c] <= tgt[c];
        end else if (tick) begin
          if (tgt[c] > duty_q[c]) begin
            duty_q[c] <= (tgt[c] - duty_q[c] > 8'(drive_behaviour_field_q[c][2:0])) ?
                         duty_q[c] + 8'(drive_behaviour_field_q[c][2:0]) : tgt[c];
          end else if (tgt[c] < duty_q[c]) begin
            duty_q[c] <= (duty_q[c] - tgt[c] > 8'(drive_behaviour_field_q[c][2:0])) ?
                         duty_q[c] - 8'(drive_behaviour_field_q[c][2:0]) : tgt[c];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // xor board test
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) o_xor_chain_out <= 1'b0;
    else o_xor_chain_out <= test_q[FCFS_XOR_EN_BIT] & ~(^{tach_s, overtemp_s, scl_s});
  end

  // ----------------------------------------------------------------
  // duty handover to the pwm clock
  // ----------------------------------------------------------------
  fcfs_drive_t hand_q, pwm_duty_q;
  logic req_q, ack_meta_q, ack_sync_q, ack_q;
  always_ff @(posedge i_clk_sys) begin
    ack_meta_q <= ack_q;
    ack_sync_q <= ack_meta_q;
    if (i_rst) begin
      req_q <= 1'b0;
      hand_q <= '0;
    end else if (req_q == ack_sync_q && hand_q.duty != duty_q) begin
      hand_q.duty <= duty_q;
      req_q <= ~req_q;
    end
  end
  logic rst_meta_q, rst_pwm_q, req_meta_q, req_sync_q;
  logic [7:0] pwm_cnt_q;
  always_ff @(posedge i_clk_pwm) begin
    rst_meta_q <= i_rst;
    rst_pwm_q <= rst_meta_q;
    req_meta_q <= req_q;
    req_sync_q <= req_meta_q;
    if (rst_pwm_q) begin
      ack_q <= 1'b0;
      pwm_duty_q <= '0;
      pwm_cnt_q <= 8'h00;
      o_fan_drive <= 3'h0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      if (req_sync_q != ack_q) begin
        pwm_duty_q <= hand_q;
        ack_q <= req_sync_q;
      end
      for (int c = 0; c < 3; c++) begin
        o_fan_drive[c] <= (pwm_duty_q.duty[c] == FCFS_DUTY_FULL) ||
                          (pwm_cnt_q < pwm_duty_q.duty[c]);
      end
    end
  end
endmodule : fcfs_supervisor

/* tb/fcfs_smb_host.sv */
/*
  smbus host model that drives the supervisor register port.
  assumes the bench resolves sda from both open-drain enables with a pull-up.
*/
`timescale 1ns/100ps
module fcfs_smb_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  import fcfs_pkg::*;
  logic ack_ok;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    ack_ok = 1'b0;
  end
  // ----------------------------------------------------------------
  // bit level
  // ----------------------------------------------------------------
  task automatic half();
    repeat (11) @(posedge i_clk);
    #1;
  endtask : half
  task automatic bit_x(input logic oe, output logic v);
    o_sda_oe = oe;
    half();
    o_scl = 1'b1;
    half();
    v = i_sda;
    o_scl = 1'b0;
    half();
  endtask : bit_x
  task automatic start_c();
    o_sda_oe = 1'b0;
    half();
    o_scl = 1'b1;
    half();
    o_sda_oe = 1'b1;
    half();
    o_scl = 1'b0;
    half();
  endtask : start_c
  task automatic stop_c();
    o_sda_oe = 1'b1;
    half();
    o_scl = 1'b1;
    half();
    o_sda_oe = 1'b0;
    half();
  endtask : stop_c
  // ----------------------------------------------------------------
  // byte and register level
  // ----------------------------------------------------------------
  task automatic tx(input logic [7:0] b, output logic [7:0] r, output logic a);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bit_x(!b[i], r[i]);
    end
    bit_x(1'b0, v);
    a = !v;
  endtask : tx
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    start_c();
    tx({FCFS_SMB_ADDR, 1'b0}, r, a0);
    tx(p, r, a1);
    tx(d, r, a2);
    stop_c();
    ack_ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start_c();
    tx({FCFS_SMB_ADDR, 1'b0}, r, a0);
    tx(p, r, a1);
    start_c();
    tx({FCFS_SMB_ADDR, 1'b1}, r, a2);
    tx(8'hff, d, a3);
    stop_c();
    ack_ok = a0 & a1 & a2;
  endtask : rd
endmodule : fcfs_smb_host

/* tb/fcfs_supervisor_checker.sv */
/*
  port assertions of the fan supervisor.
  assumes binding into fcfs_supervisor.
*/
`timescale 1ns/100ps
module fcfs_supervisor_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clk_pwm,
  input wire logic i_scl,
  input wire fcfs_pkg::fcfs_rail_t i_rail,
  input wire logic i_shutdown_req,
  input wire logic o_sda_oe,
  input wire logic o_overtemp_monitor_en,
  input wire logic o_start_temp_adjust_en,
  input wire logic o_shutdown,
  input wire logic [2:0] o_fan_drive
);
  import fcfs_pkg::*;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence s_rail_ok;
    !i_rail.below_low_limit [*4];
  endsequence
  sequence s_drv_start;
    $rose(o_sda_oe);
  endsequence
  property p_ack_scl_low;
    @(posedge i_clk_sys) disable iff (i_rst) $changed(o_sda_oe) |-> !i_scl;
  endproperty
  a_ack_scl_low: assert property (p_ack_scl_low) else $error("sda moved in scl high");
  property p_ack_hold;
    @(posedge i_clk_sys) disable iff (i_rst) s_drv_start |=> o_sda_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda drive too short");
  property p_fan_reset;
    @(posedge i_clk_pwm) i_rst [*4] |-> o_fan_drive == 3'h0;
  endproperty
  a_fan_reset: assert property (p_fan_reset) else $error("fan drive not zero in reset");
  property p_mon_cause;
    @(posedge i_clk_sys) disable iff (i_rst) !o_overtemp_monitor_en |->
      $past(i_rail.below_low_limit, 1) || $past(i_rail.below_low_limit, 2) ||
      $past(i_rail.below_low_limit, 3);
  endproperty
  a_mon_cause: assert property (p_mon_cause) else $error("monitor off without low rail");
  property p_mon_resume;
    @(posedge i_clk_sys) disable iff (i_rst) s_rail_ok |-> o_overtemp_monitor_en;
  endproperty
  a_mon_resume: assert property (p_mon_resume) else $error("monitor not resumed");
  property p_adj_suspend;
    @(posedge i_clk_sys) disable iff (i_rst) o_start_temp_adjust_en |-> o_overtemp_monitor_en;
  endproperty
  a_adj_suspend: assert property (p_adj_suspend) else $error("adjust on while suspended");
  property p_shut_block;
    @(posedge i_clk_sys) disable iff (i_rst) o_shutdown |-> o_overtemp_monitor_en;
  endproperty
  a_shut_block: assert property (p_shut_block) else $error("shutdown while suspended");
  property p_shut_cause;
    @(posedge i_clk_sys) disable iff (i_rst) $rose(o_shutdown) |-> $past(i_shutdown_req);
  endproperty
  a_shut_cause: assert property (p_shut_cause) else $error("shutdown without request");
endmodule : fcfs_supervisor_checker
bind fcfs_supervisor fcfs_supervisor_checker fcfs_supervisor_checker_inst (.i_clk_sys,
  .i_rst, .i_clk_pwm, .i_scl, .i_rail, .i_shutdown_req, .o_sda_oe, .o_overtemp_monitor_en,
  .o_start_temp_adjust_en, .o_shutdown, .o_fan_drive);

/* tb/fcfs_supervisor_tb.sv */
/*
  self-checking bench of the fan supervisor with an smbus host model.
  assumes a short fail-safe count set through the top parameter.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module fcfs_supervisor_tb;
  import fcfs_pkg::*;
  localparam longint FS_CYC = 2000;
  logic clk, clk_pwm, rst, scl, host_oe, sda_oe, sda_out, alert, mon_en, adj_en, shut, xo;
  logic shut_req, ot_n;
  logic [2:0] fan, hi, lo;
  logic [3:0] tach;
  logic [7:0] d, v;
  fcfs_temp_t temps;
  fcfs_rail_t rail;
  int err_count = 0;
  int check_count = 0;
  wire logic sda = !(host_oe | sda_oe);
  fcfs_supervisor #(.FAILSAFE_CYC(FS_CYC)) fcfs_supervisor_inst (.i_clk_sys(clk), .i_rst(rst),
    .i_clk_pwm(clk_pwm), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_temps(temps), .i_rail(rail), .i_tach(tach), .i_overtemp_pin_n(ot_n),
    .i_shutdown_req(shut_req), .o_alert(alert), .o_overtemp_monitor_en(mon_en),
    .o_start_temp_adjust_en(adj_en), .o_shutdown(shut), .o_xor_chain_out(xo), .o_fan_drive(fan));
  fcfs_smb_host hst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe(host_oe));
  // ----------------------------------------------------------------
  // clocks, helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    clk_pwm = 1'b0;
    #1.3;
    forever #3 clk_pwm = ~clk_pwm;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic do_reset(input logic det);
    rst = 1'b1;
    rail = {1'b0, det};
    step(8);
    rst = 1'b0;
  endtask : do_reset
  task automatic fan_lvl();
    hi = 3'h7;
    lo = 3'h7;
    repeat (600) begin
      @(negedge clk_pwm);
      hi &= fan;
      lo &= ~fan;
    end
  endtask : fan_lvl
  function automatic logic [7:0] exp_auto(input logic [7:0] t);
    int x;
    if (t < FCFS_START_RST) return 8'h00;
    x = int'(FCFS_MIN_RST) + (int'(t - FCFS_START_RST) << FCFS_AUTO_GAIN_SHIFT);
    return (x > 255) ? 8'hff : 8'(x);
  endfunction : exp_auto
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    temps = '0;
    shut_req = 1'b0;
    ot_n = 1'b1;
    tach = 4'h0;
    rst = 1'b1;
    rail = 2'b01;
    void'($urandom(44511));
    do_reset(1'b1);
    step(int'(FS_CYC) + 100);
    fan_lvl();
    `CHK(hi, 3'h7)
    hst.rd(FCFS_REG_DUTY1, d);
    `CHK(d, FCFS_DUTY_RST)
    `CHK(hst.ack_ok, 1'b1)
    fan_lvl();
    `CHK(lo, 3'h7)
    $display("failsafe expiry test done");
    for (int c = 0; c < 3; c++) begin
      v = 8'($urandom);
      hst.wr(FCFS_REG_BHVR1 + 8'(c), {FCFS_DRIVE_BEHAVIOUR_FIELD_MANUAL, 5'h00});
      hst.wr(FCFS_REG_DUTY1 + 8'(c), v);
      hst.rd(FCFS_REG_DUTY1 + 8'(c), d);
      `CHK(d, v)
      hst.wr(FCFS_REG_DUTY1 + 8'(c), FCFS_DUTY_FULL);
    end
    fan_lvl();
    `CHK(hi, 3'h7)
    $display("manual duty test done");
    for (int c = 0; c < 3; c++) begin
      temps.temp[c] = 8'($urandom_range(8'h90, 8'h50));
    end
    temps.temp[0] = FCFS_START_RST;
    for (int c = 0; c < 3; c++) begin
      hst.wr(FCFS_REG_BHVR1 + 8'(c), FCFS_DRIVE_BEHAVIOUR_FIELD_RST);
      hst.rd(FCFS_REG_DUTY1 + 8'(c), d);
      `CHK(d, exp_auto(temps.temp[c]))
    end
    $display("auto control test done");
    temps = '0;
    hst.wr(FCFS_REG_CFG, 8'h02);
    hst.wr(FCFS_REG_ADAPT1, 8'h03);
    shut_req = 1'b1;
    rail.below_low_limit = 1'b1;
    step(10);
    `CHK({mon_en, adj_en, shut}, 3'h0)
    `CHK(alert, 1'b1)
    hst.rd(FCFS_REG_STAT1, d);
    `CHK(d[FCFS_STAT_CORE_BIT], 1'b1)
    rail.below_low_limit = 1'b0;
    step(10);
    `CHK({mon_en, adj_en, shut}, 3'h7)
    hst.rd(FCFS_REG_STAT1, d);
    hst.rd(FCFS_REG_STAT1, d);
    `CHK(d, 8'h00)
    `CHK(alert, 1'b0)
    `CHK(sda_out, 1'b0)
    hst.rd(8'h7f, d);
    `CHK(d, 8'h00)
    $display("core rail test done");
    hst.wr(FCFS_REG_TEST, 8'h01);
    repeat (8) begin
      tach = 4'($urandom);
      ot_n = 1'($urandom);
      step(8);
      `CHK(xo, ~^{tach, ~ot_n, scl})
    end
    ot_n = 1'b1;
    $display("xor chain test done");
    do_reset(1'b0);
    step(int'(FS_CYC) + 100);
    fan_lvl();
    `CHK(lo, 3'h7)
    do_reset(1'b1);
    for (int c = 0; c < 3; c++) begin
      hst.rd(FCFS_REG_DUTY1 + 8'(c), d);
      `CHK(d, FCFS_DUTY_RST)
    end
    step(int'(FS_CYC) + 100);
    fan_lvl();
    `CHK(lo, 3'h7)
    hst.rd(FCFS_REG_TACH1 + 8'h3, d);
    `CHK(d, 8'hff)
    hst.rd(FCFS_REG_MIN1 + 8'h2, d);
    `CHK(d, FCFS_MIN_RST)
    hst.wr(FCFS_REG_START1 + 8'h1, v);
    hst.rd(FCFS_REG_START1 + 8'h1, d);
    `CHK(d, v)
    $display("power-on default test done");
    end_of_test();
  end
endmodule : fcfs_supervisor_tb
